// >>> rtl/bus_sync.sv
`timescale 1ns/100ps

// ****************************************************************
// Two-stage input register for bus pins
// ****************************************************************
module bus_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Reset value is constant per instance; idle bus levels are all ones
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule

// >>> rtl/palette_snooper.sv
`timescale 1ns/100ps
`include "palette_snoop_map.svh"

// Operation
// - active display device always answers palette reads
// - writes either claimed or snooped, never both
// - snoop capture only when IRDY and TRDY asserted, or with held IRDY data on master abort
// - capture write data on master abort too
// - snooping drives no bus signal at all
// - track transaction independent of master/target pacing
// - each word accepted in its transfer clock
// - only local segment traffic is observed
// - illegal protocol returns machine to idle when snooping, to turnaround when responding
module palette_snooper
	import palette_snoop_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        display_active_i,
	input  wire logic        snoop_en_i,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        frame_n_i,
	input  wire logic        irdy_n_i,
	input  wire logic        trdy_n_i,
	input  wire logic        devsel_n_i,
	input  wire logic        stop_n_i,
	input  wire logic [3:0]  cbe_n_i,
	input  wire logic [31:0] ad_i,
	output logic             devsel_n_o,
	output logic             devsel_oe_o,
	output logic             trdy_n_o,
	output logic             trdy_oe_o,
	output logic             stop_n_o,
	output logic             stop_oe_o,
	output logic [31:0]      ad_o,
	output logic             ad_oe_o,
	output logic             par_o,
	output logic             par_oe_o,
	output logic             cap_valid_o,
	output logic             cap_abort_o,
	output logic [31:0]      cap_addr_o,
	output logic [3:0]       cap_be_o,
	output logic [31:0]      cap_data_o,
	output logic             proto_err_o
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic in_palette(input logic [31:0] a);
		in_palette = (a >= `PAL_ADDR_LO) && (a <= `PAL_ADDR_HI);
	endfunction

	function automatic logic bus_idle(input bus_t b);
		bus_idle = b.frame_n && b.irdy_n;
	endfunction

	// ****************************************************************
	// Input stage
	// ****************************************************************
	bus_t bus_raw;
	bus_t bus;
	state_t s_q;
	state_t s_d;
	logic   rd_hit;
	logic   wr_hit;
	logic   xfer;

	assign bus_raw = '{frame_n: frame_n_i, irdy_n: irdy_n_i, trdy_n: trdy_n_i, devsel_n: devsel_n_i,
	                   stop_n: stop_n_i, cbe_n: cbe_n_i, ad: ad_i};

	// only pins of this segment are sampled
	bus_sync #(
		.W($bits(bus_t))
	) u_sync (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.d_i      (bus_raw),
		.q_o      (bus)
	);

	// address phase decode of palette range and command
	assign rd_hit = in_palette(bus.ad) && (bus.cbe_n == `CMD_IO_READ);
	assign wr_hit = in_palette(bus.ad) && (bus.cbe_n == `CMD_IO_WRITE);
	assign xfer   = !bus.irdy_n && !bus.trdy_n;

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		s_d           = s_q;
		s_d.prev_idle = bus_idle(bus);
		s_d.cap.valid = 1'b0;
		s_d.cap.abort = 1'b0;
		s_d.proto_err = 1'b0;
		s_d.drv.par   = ^{s_q.drv.ad, ~bus.cbe_n};
		s_d.drv.par_oe = s_q.drv.ad_oe;
		case (s_q.st)
			ST_IDLE: begin
				s_d.drv.devsel_oe = 1'b0;
				s_d.drv.trdy_oe   = 1'b0;
				s_d.drv.stop_oe   = 1'b0;
				s_d.drv.ad_oe     = 1'b0;
				s_d.dev_seen      = 1'b0;
				s_d.held          = 1'b0;
				if (s_q.prev_idle && !bus.frame_n) begin
					s_d.addr = bus.ad;
					// reads claimed whenever this is the active display agent
					if (rd_hit && display_active_i) begin
						s_d.is_wr = 1'b0;
						s_d.st    = ST_RESP;
					// claim writes only when not programmed to snoop
					end else if (wr_hit && display_active_i && !snoop_en_i) begin
						s_d.is_wr = 1'b1;
						s_d.st    = ST_RESP;
					// arm capture only with snoop enabled
					end else if (wr_hit && snoop_en_i) begin
						s_d.is_wr = 1'b1;
						s_d.st    = ST_SNOOP;
					end else begin
						s_d.st = ST_WAIT;
					end
				// data handshake with no address phase is illegal
				end else if (bus.frame_n && !bus.irdy_n && !bus.trdy_n) begin
					s_d.proto_err = 1'b1;
				end
			end
			ST_SNOOP: begin
				// outputs stay released for the whole snoop
				s_d.drv.devsel_oe = 1'b0;
				s_d.drv.trdy_oe   = 1'b0;
				s_d.drv.stop_oe   = 1'b0;
				s_d.drv.ad_oe     = 1'b0;
				// follow whatever pace the owners choose
				if (!bus.devsel_n) begin
					s_d.dev_seen = 1'b1;
				end
				if (!bus.irdy_n) begin
					s_d.held    = 1'b1;
					s_d.hold_ad = bus.ad;
					s_d.hold_be = ~bus.cbe_n;
				end
				// target ready without select is illegal, drop out
				if (!bus.trdy_n && bus.devsel_n) begin
					s_d.proto_err = 1'b1;
					s_d.st        = ST_IDLE;
				// capture only on a completed data transfer
				end else if (xfer) begin
					// word handed on in its own transfer clock
					s_d.cap.valid = 1'b1;
					s_d.cap.addr  = s_q.addr;
					s_d.cap.be    = ~bus.cbe_n;
					s_d.cap.data  = bus.ad;
					s_d.held      = 1'b0;
					s_d.addr      = s_q.addr + 32'h0000_0004;
				end else if (bus_idle(bus)) begin
					// nobody selected, keep the master-aborted data
					if (!s_q.dev_seen && s_q.held) begin
						s_d.cap.valid = 1'b1;
						s_d.cap.abort = 1'b1;
						s_d.cap.addr  = s_q.addr;
						s_d.cap.be    = s_q.hold_be;
						s_d.cap.data  = s_q.hold_ad;
					end
					s_d.st = ST_IDLE;
				end
			end
			ST_RESP: begin
				// Single data phase: disconnect with data keeps the sequence short
				s_d.drv.devsel_n  = 1'b0;
				s_d.drv.devsel_oe = 1'b1;
				s_d.drv.trdy_n    = 1'b0;
				s_d.drv.trdy_oe   = 1'b1;
				s_d.drv.stop_n    = 1'b0;
				s_d.drv.stop_oe   = 1'b1;
				s_d.drv.ad        = rd_data_i;
				s_d.drv.ad_oe     = !s_q.is_wr;
				if (xfer) begin
					if (s_q.is_wr) begin
						s_d.cap.valid = 1'b1;
						s_d.cap.addr  = s_q.addr;
						s_d.cap.be    = ~bus.cbe_n;
						s_d.cap.data  = bus.ad;
					end
					s_d.st = ST_TURN;
				end else if (bus_idle(bus)) begin
					s_d.proto_err = 1'b1;
					s_d.st        = ST_TURN;
				end
			end
			ST_TURN: begin
				// drive high one clock before release
				s_d.drv.devsel_n = 1'b1;
				s_d.drv.trdy_n   = 1'b1;
				s_d.drv.stop_n   = 1'b1;
				s_d.drv.ad_oe    = 1'b0;
				s_d.st           = ST_WAIT;
			end
			ST_WAIT: begin
				s_d.drv.devsel_oe = 1'b0;
				s_d.drv.trdy_oe   = 1'b0;
				s_d.drv.stop_oe   = 1'b0;
				s_d.drv.ad_oe     = 1'b0;
				if (bus_idle(bus)) begin
					s_d.st = ST_IDLE;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_q.st         <= ST_IDLE;
			s_q.prev_idle  <= 1'b1;
			s_q.dev_seen   <= 1'b0;
			s_q.held       <= 1'b0;
			s_q.is_wr      <= 1'b0;
			s_q.addr       <= `RST_DATA;
			s_q.hold_ad    <= `RST_DATA;
			s_q.hold_be    <= 4'h0;
			s_q.drv        <= '{devsel_n: 1'b1, devsel_oe: 1'b0, trdy_n: 1'b1, trdy_oe: 1'b0, stop_n: 1'b1,
			                    stop_oe: 1'b0, ad: `RST_DATA, ad_oe: 1'b0, par: 1'b0, par_oe: 1'b0};
			s_q.cap        <= '{valid: 1'b0, abort: 1'b0, addr: `RST_DATA, be: 4'h0, data: `RST_DATA};
			s_q.proto_err  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign devsel_n_o  = s_q.drv.devsel_n;
	assign devsel_oe_o = s_q.drv.devsel_oe;
	assign trdy_n_o    = s_q.drv.trdy_n;
	assign trdy_oe_o   = s_q.drv.trdy_oe;
	assign stop_n_o    = s_q.drv.stop_n;
	assign stop_oe_o   = s_q.drv.stop_oe;
	assign ad_o        = s_q.drv.ad;
	assign ad_oe_o     = s_q.drv.ad_oe;
	assign par_o       = s_q.drv.par;
	assign par_oe_o    = s_q.drv.par_oe;
	assign cap_valid_o = s_q.cap.valid;
	assign cap_abort_o = s_q.cap.abort;
	assign cap_addr_o  = s_q.cap.addr;
	assign cap_be_o    = s_q.cap.be;
	assign cap_data_o  = s_q.cap.data;
	assign proto_err_o = s_q.proto_err;

endmodule

// >>> shared/palette_snoop_map.svh
`ifndef PALETTE_SNOOP_MAP_SVH
`define PALETTE_SNOOP_MAP_SVH

// ****************************************************************
// Palette address window (I/O space, byte addresses)
// ****************************************************************
`define PAL_ADDR_LO   32'h0000_03c6
`define PAL_ADDR_HI   32'h0000_03c9

// ****************************************************************
// Bus command codes on the command/byte-enable lines
// ****************************************************************
`define CMD_IO_READ   4'h2
`define CMD_IO_WRITE  4'h3

// ****************************************************************
// Input stage and reset values
// ****************************************************************
`define SYNC_STAGES   2
`define RST_DATA      32'h0000_0000

`endif

// >>> shared/palette_snoop_pkg.sv
package palette_snoop_pkg;

	// ****************************************************************
	// Bus sample as seen through the input stage (active-low kept)
	// ****************************************************************
	typedef struct packed {
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic [3:0]  cbe_n;
		logic [31:0] ad;
	} bus_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SNOOP = 3'b001,
		ST_RESP  = 3'b010,
		ST_TURN  = 3'b011,
		ST_WAIT  = 3'b100
	} snoop_state_t;

	// ****************************************************************
	// Captured palette write handed to the user side
	// ****************************************************************
	typedef struct packed {
		logic        valid;
		logic        abort;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] data;
	} capture_t;

	// ****************************************************************
	// Signals this agent drives onto the bus
	// ****************************************************************
	typedef struct packed {
		logic        devsel_n;
		logic        devsel_oe;
		logic        trdy_n;
		logic        trdy_oe;
		logic        stop_n;
		logic        stop_oe;
		logic [31:0] ad;
		logic        ad_oe;
		logic        par;
		logic        par_oe;
	} drive_t;

	typedef struct packed {
		snoop_state_t st;
		logic         prev_idle;
		logic         dev_seen;
		logic         held;
		logic         is_wr;
		logic [31:0]  addr;
		logic [31:0]  hold_ad;
		logic [3:0]   hold_be;
		drive_t       drv;
		capture_t     cap;
		logic         proto_err;
	} state_t;

endpackage

// >>> sim/bus_partner.sv
`timescale 1ns/100ps
module bus_partner (
	input  wire logic        clk_i,
	input  wire logic        dsel_n_i,
	input  wire logic        dsel_oe_i,
	input  wire logic        rdy_n_i,
	input  wire logic        rdy_oe_i,
	input  wire logic        stp_n_i,
	input  wire logic        stp_oe_i,
	input  wire logic [31:0] dat_i,
	input  wire logic        dat_oe_i,
	output logic             frame_n_o,
	output logic             irdy_n_o,
	output logic             trdy_n_o,
	output logic             devsel_n_o,
	output logic             stop_n_o,
	output logic [3:0]       cbe_n_o,
	output logic [31:0]      ad_o
);
	logic        t_devsel_n = 1'b1;
	logic        t_trdy_n = 1'b1;
	logic [31:0] m_ad = 32'h0;
	// Control lines have pull-ups, so an undriven line reads high
	assign devsel_n_o = dsel_oe_i ? dsel_n_i : t_devsel_n;
	assign trdy_n_o = rdy_oe_i ? rdy_n_i : t_trdy_n;
	assign stop_n_o = stp_oe_i ? stp_n_i : 1'b1;
	assign ad_o = dat_oe_i ? dat_i : m_ad;
	initial begin
		frame_n_o = 1'b1;
		irdy_n_o = 1'b1;
		cbe_n_o = 4'hf;
	end
	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask
	// claim: 0 none, 1 fast target, 2 snooper side, 3 ready without select
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d, input int claim,
		output logic ok, output logic [31:0] rd);
		int n;
		frame_n_o = 1'b0;
		m_ad = a;
		cbe_n_o = cmd;
		tick();
		frame_n_o = 1'b1;
		irdy_n_o = 1'b0;
		m_ad = (cmd == 4'h2) ? ~a : d;
		cbe_n_o = 4'h0;
		t_devsel_n = (claim != 1);
		t_trdy_n = (claim != 1) && (claim != 3);
		n = 0;
		while (claim == 2 && !(rdy_oe_i && !rdy_n_i) && n < 12) begin
			tick();
			n++;
		end
		ok = (n < 12);
		rd = dat_i;
		// master-abort waits out the select window
		repeat (claim == 0 ? 5 : 1) tick();
		irdy_n_o = 1'b1;
		t_devsel_n = 1'b1;
		t_trdy_n = 1'b1;
		m_ad = ~m_ad;
		cbe_n_o = ~cbe_n_o;
		repeat (8) tick();
	endtask
	// data handshake with no transaction open
	task automatic glitch();
		irdy_n_o = 1'b0;
		t_trdy_n = 1'b0;
		tick();
		irdy_n_o = 1'b1;
		t_trdy_n = 1'b1;
		repeat (8) tick();
	endtask
endmodule

// >>> sim/palette_snooper_assertions.sv
`timescale 1ns/100ps
`include "palette_snoop_map.svh"
module snoop_checker (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        display_active_i,
	input wire logic        snoop_en_i,
	input wire logic        frame_n_i,
	input wire logic        irdy_n_i,
	input wire logic        trdy_n_i,
	input wire logic [3:0]  cbe_n_i,
	input wire logic [31:0] ad_i,
	input wire logic        devsel_n_o,
	input wire logic        devsel_oe_o,
	input wire logic        trdy_n_o,
	input wire logic        trdy_oe_o,
	input wire logic        stop_n_o,
	input wire logic        stop_oe_o,
	input wire logic        ad_oe_o,
	input wire logic        par_oe_o,
	input wire logic        cap_valid_o,
	input wire logic        cap_abort_o,
	input wire logic        proto_err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	chk_snoop_quiet: assert property (
		snoop_en_i && !display_active_i |-> !(devsel_oe_o || trdy_oe_o || stop_oe_o || ad_oe_o || par_oe_o))
		else $error("bus driven while snooping");
	chk_cap_on_xfer: assert property (
		snoop_en_i && cap_valid_o && !cap_abort_o |-> $past(!irdy_n_i && !trdy_n_i, 3))
		else $error("capture without data transfer");
	chk_abort_flag: assert property (
		cap_abort_o |-> cap_valid_o)
		else $error("abort flag without capture");
	chk_read_claim: assert property (
		display_active_i && !frame_n_i && $past(frame_n_i) && $past(irdy_n_i) && cbe_n_i == `CMD_IO_READ
		&& ad_i >= `PAL_ADDR_LO && ad_i <= `PAL_ADDR_HI |-> ##4 devsel_oe_o && !devsel_n_o)
		else $error("palette read not claimed");
	chk_trdy_devsel: assert property (
		trdy_oe_o |-> devsel_oe_o)
		else $error("ready driven without select");
	chk_par_follow: assert property (
		$rose(ad_oe_o) |=> par_oe_o)
		else $error("parity not driven after data");
	chk_sel_release: assert property (
		$fell(devsel_oe_o) |-> $past(devsel_n_o))
		else $error("select released while low");
	chk_err_pulse: assert property (
		proto_err_o |=> !proto_err_o)
		else $error("error flag longer than a cycle");
	chk_stop_with_ready: assert property (
		stop_oe_o |-> trdy_oe_o && stop_n_o == trdy_n_o)
		else $error("stop not paired with ready");
	cover property (cap_valid_o && !cap_abort_o);
	cover property (cap_abort_o);
	cover property (trdy_oe_o && !ad_oe_o);
	cover property (proto_err_o);
endmodule

bind palette_snooper snoop_checker i_chk (.clk_i, .reset_i, .display_active_i, .snoop_en_i, .frame_n_i,
	.irdy_n_i, .trdy_n_i, .cbe_n_i, .ad_i, .devsel_n_o, .devsel_oe_o, .trdy_n_o, .trdy_oe_o, .stop_n_o,
	.stop_oe_o, .ad_oe_o,
	.par_oe_o, .cap_valid_o, .cap_abort_o, .proto_err_o);

// >>> sim/palette_write_snooper_tb_top.sv
`timescale 1ns/100ps
`include "palette_snoop_map.svh"
module palette_write_snooper_tb_top;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        display_active_i = 1'b0;
	logic        snoop_en_i = 1'b1;
	logic [31:0] rd_data_i = 32'hcafe_0042;
	logic        frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i, stop_n_i;
	logic [3:0]  cbe_n_i, cap_be_o;
	logic [31:0] ad_i, ad_o, cap_addr_o, cap_data_o, rd;
	logic        devsel_n_o, devsel_oe_o, trdy_n_o, trdy_oe_o, stop_n_o, stop_oe_o, ad_oe_o, par_o, par_oe_o;
	logic        cap_valid_o, cap_abort_o, proto_err_o, ok, c_abort;
	int          n_mismatch = 0, total_checks = 0, n_cap = 0, n_err = 0, n;
	always #5 clk_i = ~clk_i;
	palette_snooper i_dut (.clk_i, .reset_i, .display_active_i, .snoop_en_i, .rd_data_i, .frame_n_i, .irdy_n_i,
		.trdy_n_i, .devsel_n_i, .stop_n_i, .cbe_n_i, .ad_i, .devsel_n_o, .devsel_oe_o, .trdy_n_o, .trdy_oe_o,
		.stop_n_o, .stop_oe_o, .ad_o, .ad_oe_o, .par_o, .par_oe_o, .cap_valid_o, .cap_abort_o, .cap_addr_o,
		.cap_be_o, .cap_data_o, .proto_err_o);
	bus_partner i_bus (.clk_i(clk_i), .dsel_n_i(devsel_n_o), .dsel_oe_i(devsel_oe_o), .rdy_n_i(trdy_n_o),
		.rdy_oe_i(trdy_oe_o), .stp_n_i(stop_n_o), .stp_oe_i(stop_oe_o), .dat_i(ad_o), .dat_oe_i(ad_oe_o),
		.frame_n_o(frame_n_i), .irdy_n_o(irdy_n_i), .trdy_n_o(trdy_n_i), .devsel_n_o(devsel_n_i),
		.stop_n_o(stop_n_i), .cbe_n_o(cbe_n_i), .ad_o(ad_i));
	always @(posedge clk_i) begin
		n_cap += (cap_valid_o === 1'b1);
		n_err += (proto_err_o === 1'b1);
		if (cap_valid_o === 1'b1)
			c_abort = cap_abort_o;
	end
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded handshake: a stuck transfer ends the run
	task automatic xf(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d, input int claim);
		n = n_cap;
		i_bus.xfer(cmd, a, d, claim, ok, rd);
		check("handshake", 32'h1, {31'h0, ok});
		if (ok !== 1'b1)
			summarize();
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic s_snoop();
		xf(`CMD_IO_WRITE, 32'h3c8, 32'h1234_abcd, 1);
		check("capture count", 32'h1, 32'(n_cap - n));
		check("capture data", 32'h1234_abcd, cap_data_o);
		check("capture addr", 32'h3c8, cap_addr_o);
		check("capture be", 32'hf, {28'h0, cap_be_o});
		check("abort flag", 32'h0, {31'h0, c_abort});
	endtask
	task automatic s_abort();
		xf(`CMD_IO_WRITE, 32'h3c6, 32'h0055_aa01, 0);
		check("abort count", 32'h1, 32'(n_cap - n));
		check("abort data", 32'h0055_aa01, cap_data_o);
		check("abort flag", 32'h1, {31'h0, c_abort});
	endtask
	task automatic s_miss();
		xf(`CMD_IO_WRITE, 32'h3ca, 32'h0bad_0001, 1);
		check("out of window", 32'h0, 32'(n_cap - n));
		xf(`CMD_IO_READ, 32'h3c8, 32'h0, 1);
		check("read not captured", 32'h0, 32'(n_cap - n));
	endtask
	task automatic s_claim();
		display_active_i = 1'b1;
		for (int s = 0; s < 2; s++) begin
			snoop_en_i = s[0];
			xf(`CMD_IO_READ, 32'h3c9, 32'h0, 2);
			check("read data", rd_data_i, rd);
			check("read parity", {31'h0, ^rd_data_i}, {31'h0, par_o});
		end
		snoop_en_i = 1'b0;
		xf(`CMD_IO_WRITE, 32'h3c7, 32'h7e57_0003, 2);
		check("claimed write", 32'h7e57_0003, cap_data_o);
		display_active_i = 1'b0;
		snoop_en_i = 1'b1;
	endtask
	task automatic s_err();
		int e;
		e = n_err;
		i_bus.glitch();
		check("protocol error", 32'h1, 32'(n_err - e));
		e = n_err;
		xf(`CMD_IO_WRITE, 32'h3c8, 32'h0bad_0002, 3);
		check("rogue ready error", 32'h1, 32'(n_err - e));
		check("rogue ready capture", 32'h0, 32'(n_cap - n));
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		#1 reset_i = 1'b0;
		repeat (4) i_bus.tick();
		s_snoop();
		s_abort();
		s_miss();
		s_claim();
		s_err();
		summarize();
	end
endmodule
